// *** rtl/qst_defines.svh ***
// Offsets, reset values and divider counts of the quarter-second counter
`ifndef QST_DEFINES_SVH
`define QST_DEFINES_SVH

`define QST_ADR_CTRL 4'h0
`define QST_ADR_STAT 4'h4
`define QST_ADR_MATCH 4'h8
`define QST_ADR_COUNT 4'hC

`define QST_CTRL_RST 8'h01
`define QST_STAT_RST 8'h00
`define QST_MATCH_RST 8'h00
`define QST_COUNT_RST 8'h00

`define QST_SRC_EXT 2'h0
`define QST_SRC_LPO 2'h1
`define QST_SRC_REF 2'h2

`define QST_PS_1K 3'h0
`define QST_PS_32K768 3'h1
`define QST_PS_32K 3'h2
`define QST_PS_38K4 3'h3
`define QST_PS_4M9152 3'h4
`define QST_PS_4M 3'h5
`define QST_PS_8M 3'h6
`define QST_PS_16M 3'h7

`define QST_PRE_1 9'h001
`define QST_PRE_128 9'h080
`define QST_PRE_125 9'h07D
`define QST_PRE_250 9'h0FA
`define QST_PRE_500 9'h1F4

`define QST_QDIV_250 14'h00FA
`define QST_QDIV_8192 14'h2000
`define QST_QDIV_8000 14'h1F40
`define QST_QDIV_9600 14'h2580

`define QST_SEC_PHASE 2'h0
`define QST_LAST_PHASE 2'h3

`endif

// *** rtl/qst_pkg.sv ***
// Types shared by the quarter-second counter files
package qst_pkg;

	typedef struct packed {
		logic module_enable_bit;
		logic [1:0] source_select_field;
		logic count_clear_bit;
		logic divided_output_enable;
		logic [2:0] divider_field;
	} qst_ctrl_t;

	typedef struct packed {
		logic quarter_tick_flag;
		logic one_second_flag;
		logic alarm_flag;
		logic quarter_tick_irq_enable;
		logic one_second_irq_enable;
		logic alarm_irq_enable;
		logic alarm_function_enable;
		logic alarm_write_done;
	} qst_stat_t;

	typedef enum logic [1:0] {
		QST_BUS_IDLE = 2'b01,
		QST_BUS_ACK = 2'b10
	} qst_bus_state_t;

endpackage

// *** rtl/qst_prescaler.sv ***
// Source edge divider producing the 4 Hz tick and the divided clock level
`timescale 1ns/1ps
`include "qst_defines.svh"

module qst_prescaler #(
	parameter int PW = 9,
	parameter int QW = 14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic src_i,
	input wire logic [2:0] ps_i,
	output logic tick_o,
	output logic lvl_o
);

	function automatic logic [PW-1:0] pre_div(input logic [2:0] ps);
		unique case (ps)
			`QST_PS_4M9152: pre_div = `QST_PRE_128;
			`QST_PS_4M: pre_div = `QST_PRE_125;
			`QST_PS_8M: pre_div = `QST_PRE_250;
			`QST_PS_16M: pre_div = `QST_PRE_500;
			default: pre_div = `QST_PRE_1;
		endcase
	endfunction

	function automatic logic [QW-1:0] q_div(input logic [2:0] ps);
		unique case (ps)
			`QST_PS_1K: q_div = `QST_QDIV_250;
			`QST_PS_32K768: q_div = `QST_QDIV_8192;
			`QST_PS_38K4, `QST_PS_4M9152: q_div = `QST_QDIV_9600;
			default: q_div = `QST_QDIV_8000;
		endcase
	endfunction

	logic src_reg, src_next;
	logic [PW-1:0] pre_reg, pre_next;
	logic [QW-1:0] q_reg, q_next;
	logic tick_reg, tick_next;
	logic lvl_reg, lvl_next;
	logic src_edge, pre_edge;
	logic [PW-1:0] pre_n;

	always_comb begin
		pre_n = pre_div(ps_i);
		src_next = src_i;
		src_edge = src_i & ~src_reg;
		pre_next = pre_reg;
		pre_edge = 1'b0;
		q_next = q_reg;
		tick_next = 1'b0;
		if (src_edge) begin
			if (pre_reg == pre_n - 1'b1) begin
				pre_next = '0;
				pre_edge = 1'b1;
			end else begin
				pre_next = pre_reg + 1'b1;
			end
		end
		if (pre_edge) begin
			if (q_reg == q_div(ps_i) - 1'b1) begin
				q_next = '0;
				tick_next = 1'b1;
			end else begin
				q_next = q_reg + 1'b1;
			end
		end
		// Slow inputs pass straight through; fast ones use the pre-divider
		if (pre_n == `QST_PRE_1)
			lvl_next = src_reg;
		else
			lvl_next = (pre_reg < (pre_n >> 1));
		if (!run_i) begin
			pre_next = '0;
			q_next = '0;
			tick_next = 1'b0;
			lvl_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_reg <= 1'b0;
			pre_reg <= '0;
			q_reg <= '0;
			tick_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			src_reg <= src_next;
			pre_reg <= pre_next;
			q_reg <= q_next;
			tick_reg <= tick_next;
			lvl_reg <= lvl_next;
		end
	end

	assign tick_o = tick_reg;
	assign lvl_o = lvl_reg;

endmodule

// *** rtl/qst_time_counter.sv ***
// Quarter-second time counter with Wishbone register access
`timescale 1ns/1ps
`include "qst_defines.svh"

module qst_time_counter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_osc_clk_i,
	input wire logic low_power_osc_i,
	input wire logic internal_ref_clk_i,
	output logic irq_o,
	output logic clk_out_o
);

	function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
		hit = (adr[3:2] == off[3:2]);
	endfunction

	qst_pkg::qst_bus_state_t state_reg, state_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;

	qst_pkg::qst_ctrl_t tick_control_reg, tick_control_next;
	qst_pkg::qst_stat_t tick_status_control_reg, tick_status_control_next;
	logic [7:0] alarm_compare_value_reg, alarm_compare_value_next;
	logic [7:0] stage_reg, stage_next;
	logic [7:0] count_reg, count_next;
	logic irq_reg, irq_next;
	logic clk_out_reg, clk_out_next;

	logic wr, wr_ctrl, wr_stat, wr_match;
	logic src_sel, tick, lvl, run, match;
	logic [7:0] inc;
	qst_pkg::qst_ctrl_t wctl;
	qst_pkg::qst_stat_t wst;

	// Bus side: one wait state, read data captured when the request is taken
	always_comb begin
		state_next = state_reg;
		ack_next = 1'b0;
		dat_next = dat_reg;
		unique case (state_reg)
			qst_pkg::QST_BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					state_next = qst_pkg::QST_BUS_ACK;
					ack_next = 1'b1;
					dat_next = '0;
					if (hit(wb_adr_i, `QST_ADR_CTRL))
						dat_next[7:0] = tick_control_reg;
					else if (hit(wb_adr_i, `QST_ADR_STAT))
						dat_next[7:0] = tick_status_control_reg;
					else if (hit(wb_adr_i, `QST_ADR_MATCH))
						dat_next[7:0] = stage_reg;
					else
						dat_next[7:0] = count_reg;
				end
			end
			qst_pkg::QST_BUS_ACK: begin
				state_next = qst_pkg::QST_BUS_IDLE;
			end
			default: begin
				state_next = qst_pkg::QST_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= qst_pkg::QST_BUS_IDLE;
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			state_reg <= state_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// Writes land on the edge where the master sees ack
	assign wr = (state_reg == qst_pkg::QST_BUS_ACK) && wb_cyc_i && wb_stb_i
		&& wb_we_i && wb_sel_i[0];
	assign wr_ctrl = wr && hit(wb_adr_i, `QST_ADR_CTRL);
	assign wr_stat = wr && hit(wb_adr_i, `QST_ADR_STAT);
	assign wr_match = wr && hit(wb_adr_i, `QST_ADR_MATCH);
	assign wctl = wb_dat_i[7:0];
	assign wst = wb_dat_i[7:0];

	always_comb begin
		unique case (tick_control_reg.source_select_field)
			`QST_SRC_EXT: src_sel = ext_osc_clk_i;
			`QST_SRC_LPO: src_sel = low_power_osc_i;
			`QST_SRC_REF: src_sel = internal_ref_clk_i;
			default: src_sel = 1'b0;
		endcase
	end

	assign run = tick_control_reg.module_enable_bit;

	qst_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.src_i(src_sel),
		.ps_i(tick_control_reg.divider_field),
		.tick_o(tick),
		.lvl_o(lvl)
	);

	assign inc = count_reg + 8'h01;
	assign match = tick_status_control_reg.alarm_function_enable
		&& (inc[7:2] == alarm_compare_value_reg[7:2]);

	always_comb begin
		tick_control_next = tick_control_reg;
		tick_status_control_next = tick_status_control_reg;
		alarm_compare_value_next = alarm_compare_value_reg;
		stage_next = stage_reg;
		count_next = count_reg;
		if (wr_ctrl) begin
			tick_control_next = wctl;
			// Clear bit is an action, never stored
			tick_control_next.count_clear_bit = 1'b0;
		end
		if (wr_stat) begin
			tick_status_control_next.quarter_tick_irq_enable =
				wst.quarter_tick_irq_enable;
			tick_status_control_next.one_second_irq_enable =
				wst.one_second_irq_enable;
			tick_status_control_next.alarm_irq_enable = wst.alarm_irq_enable;
			tick_status_control_next.alarm_function_enable =
				wst.alarm_function_enable;
			if (wst.quarter_tick_flag)
				tick_status_control_next.quarter_tick_flag = 1'b0;
			if (wst.one_second_flag)
				tick_status_control_next.one_second_flag = 1'b0;
			if (wst.alarm_flag)
				tick_status_control_next.alarm_flag = 1'b0;
		end
		// Second write while one is pending is dropped
		if (wr_match && !tick_status_control_reg.alarm_write_done) begin
			stage_next = wb_dat_i[7:0];
			tick_status_control_next.alarm_write_done = 1'b1;
		end
		// Pending value commits at a tick, or at once when stopped
		if (tick_status_control_reg.alarm_write_done && (tick || !run)) begin
			alarm_compare_value_next = stage_reg;
			tick_status_control_next.alarm_write_done = 1'b0;
		end
		if (run && tick) begin
			count_next = inc;
			tick_status_control_next.quarter_tick_flag = 1'b1;
			if (inc[1:0] == `QST_SEC_PHASE)
				tick_status_control_next.one_second_flag = 1'b1;
			if (match) begin
				tick_status_control_next.alarm_flag = 1'b1;
				count_next[7:2] = '0;
			end
		end
		// Stopping the module or the clear bit restarts from zero
		if (!run || (wr_ctrl && wctl.count_clear_bit))
			count_next = `QST_COUNT_RST;
	end

	always_comb begin
		irq_next = (tick_status_control_next.quarter_tick_flag
			&& tick_status_control_next.quarter_tick_irq_enable)
			|| (tick_status_control_next.one_second_flag
			&& tick_status_control_next.one_second_irq_enable)
			|| (tick_status_control_next.alarm_flag
			&& tick_status_control_next.alarm_irq_enable
			&& tick_status_control_next.alarm_function_enable);
		clk_out_next = tick_control_next.module_enable_bit
			&& tick_control_next.divided_output_enable && lvl;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_control_reg <= `QST_CTRL_RST;
			tick_status_control_reg <= `QST_STAT_RST;
			alarm_compare_value_reg <= `QST_MATCH_RST;
			stage_reg <= `QST_MATCH_RST;
			count_reg <= `QST_COUNT_RST;
			irq_reg <= 1'b0;
			clk_out_reg <= 1'b0;
		end else begin
			tick_control_reg <= tick_control_next;
			tick_status_control_reg <= tick_status_control_next;
			alarm_compare_value_reg <= alarm_compare_value_next;
			stage_reg <= stage_next;
			count_reg <= count_next;
			irq_reg <= irq_next;
			clk_out_reg <= clk_out_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o = irq_reg;
	assign clk_out_o = clk_out_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_reset_defaults: assert property (disable iff (1'b0)
		rst_i |=> tick_control_reg == `QST_CTRL_RST && count_reg == 8'h00
		&& tick_status_control_reg == `QST_STAT_RST && !irq_o)
		else $error("reset state wrong");

	a_clear_restart: assert property (
		wr_ctrl && wctl.count_clear_bit |=> count_reg == 8'h00)
		else $error("clear bit did not zero count");

	a_tick_advance: assert property (
		run && tick && !wr_ctrl && !match |=> count_reg == $past(inc))
		else $error("count did not advance on tick");

	a_quarter_flag: assert property (
		run && tick |=> tick_status_control_reg.quarter_tick_flag)
		else $error("quarter flag missing");

	a_second_flag: assert property (
		run && tick && count_reg[1:0] == `QST_LAST_PHASE
		|=> tick_status_control_reg.one_second_flag)
		else $error("second flag missing at fourth tick");

	a_match_wrap: assert property (
		run && tick && match && !wr_ctrl
		|=> count_reg[7:2] == 6'h00 && tick_status_control_reg.alarm_flag)
		else $error("match did not wrap count");

	a_alarm_gate: assert property (
		$rose(tick_status_control_reg.alarm_flag)
		|-> $past(tick_status_control_reg.alarm_function_enable))
		else $error("alarm flag without alarm enable");

	a_flag_clear: assert property (
		wr_stat && wst.quarter_tick_flag && !(run && tick)
		|=> !tick_status_control_reg.quarter_tick_flag)
		else $error("write one did not clear flag");

	a_irq_follow: assert property (
		tick_status_control_reg.one_second_flag
		&& tick_status_control_reg.one_second_irq_enable && !wr_stat
		|=> irq_o)
		else $error("interrupt not raised for enabled flag");

	a_clkout_off: assert property (
		!tick_control_reg.divided_output_enable && !wr_ctrl |=> !clk_out_o)
		else $error("clock output active while disabled");

	a_alarm_irq: assert property (
		tick_status_control_reg.alarm_flag
		&& tick_status_control_reg.alarm_irq_enable
		&& tick_status_control_reg.alarm_function_enable && !wr_stat
		|=> irq_o)
		else $error("enabled alarm flag gave no interrupt");

	a_irq_source: assert property (
		irq_o |-> ((tick_status_control_reg.quarter_tick_flag
		&& tick_status_control_reg.quarter_tick_irq_enable)
		|| (tick_status_control_reg.one_second_flag
		&& tick_status_control_reg.one_second_irq_enable)
		|| (tick_status_control_reg.alarm_flag
		&& tick_status_control_reg.alarm_irq_enable)))
		else $error("interrupt without an enabled flag");

	a_second_phase: assert property (
		$rose(tick_status_control_reg.one_second_flag)
		|-> count_reg[1:0] == `QST_SEC_PHASE)
		else $error("second flag away from a second boundary");

	a_quarter_cause: assert property (
		$rose(tick_status_control_reg.quarter_tick_flag)
		|-> $past(tick) && $past(run))
		else $error("quarter flag without a tick");

	a_count_hold: assert property (
		run && !tick && !wr_ctrl |=> count_reg == $past(count_reg))
		else $error("count moved between ticks");

	a_idle_count: assert property (
		!run |=> count_reg == `QST_COUNT_RST)
		else $error("count moved while module disabled");

endmodule

// *** test/tb_top.sv ***
// Register-level bench for the quarter-second time counter
`timescale 1ns/1ps
`include "qst_defines.svh"

module tb_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic ext_osc_clk_i, low_power_osc_i, internal_ref_clk_i;
	logic irq_o, clk_out_o;
	logic [2:0] src_on;
	logic [7:0] rd;
	int err_count, num_checks, n;

	qst_time_counter uut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ext_osc_clk_i(ext_osc_clk_i), .low_power_osc_i(low_power_osc_i),
		.internal_ref_clk_i(internal_ref_clk_i), .irq_o(irq_o),
		.clk_out_o(clk_out_o));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Fastest legal source: one rising edge every two cycles
	always @(posedge clk_i) begin
		ext_osc_clk_i <= src_on[0] & ~ext_osc_clk_i;
		low_power_osc_i <= src_on[1] & ~low_power_osc_i;
		internal_ref_clk_i <= src_on[2] & ~internal_ref_clk_i;
	end

	task fail(input string msg);
		err_count++;
		$display("Error at %0t: %s", $time, msg);
	endtask

	task end_of_test;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task wb_xfer(input logic we, input logic [3:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		wb_sel_i <= 4'h1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (k >= 20) begin
			fail("no bus acknowledge");
			end_of_test();
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		wb_xfer(1'b1, a, d);
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp)
			fail($sformatf("%s: got %h expected %h", what, got, exp));
	endtask

	task rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
		wb_xfer(1'b0, a, 8'h00);
		chk(rd, exp, what);
	endtask

	task wait_irq(input int lim);
		n = 0;
		while (irq_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim) begin
			fail("interrupt never rose");
			end_of_test();
		end
	endtask

	// Control byte: enable, source, clear, output enable, divider
	function automatic logic [7:0] cb(input logic en, input logic [1:0] s,
		input logic [2:0] d);
		return {en, s, 1'b0, 1'b0, d};
	endfunction

	int cyc_tab [2] = '{16384, 19200};
	logic [1:0] src_tab [2] = '{2'h0, 2'h2};
	logic [2:0] div_tab [2] = '{3'h1, 3'h3};

	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		{ext_osc_clk_i, low_power_osc_i, internal_ref_clk_i} = 3'h0;
		src_on = 3'h0;
		err_count = 0;
		num_checks = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(`QST_ADR_CTRL, `QST_CTRL_RST, "control reset");
		rchk(`QST_ADR_STAT, `QST_STAT_RST, "status reset");
		rchk(`QST_ADR_MATCH, `QST_MATCH_RST, "match reset");
		rchk(`QST_ADR_COUNT, `QST_COUNT_RST, "count reset");
		chk({6'h00, irq_o, clk_out_o}, 8'h00, "outputs at reset");
		$display("Test reset values done");
		for (int s = 0; s < 3; s++) begin
			src_on <= 3'h1 << s;
			wr(`QST_ADR_CTRL, cb(1'b0, 2'(s), 3'h0));
			wr(`QST_ADR_CTRL, cb(1'b1, 2'(s), 3'h0));
			repeat (1200) @(posedge clk_i);
			rchk(`QST_ADR_COUNT, 8'h02, "selected source count");
			wr(`QST_ADR_CTRL, cb(1'b0, 2'(s), 3'h0));
			src_on <= ~(3'h1 << s);
			wr(`QST_ADR_CTRL, cb(1'b1, 2'(s), 3'h0));
			repeat (1200) @(posedge clk_i);
			rchk(`QST_ADR_COUNT, 8'h00, "other source count");
			wr(`QST_ADR_CTRL, cb(1'b0, 2'(s), 3'h0));
		end
		$display("Test source select done");
		src_on <= 3'h7;
		wr(`QST_ADR_STAT, 8'hF0);
		wr(`QST_ADR_CTRL, 8'hA0);
		wait_irq(1200);
		rchk(`QST_ADR_COUNT, 8'h01, "first tick count");
		rchk(`QST_ADR_STAT, 8'h90, "quarter flag");
		wr(`QST_ADR_STAT, 8'h88);
		repeat (2) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, "irq after clear");
		rchk(`QST_ADR_STAT, 8'h08, "quarter flag cleared");
		wait_irq(2000);
		rchk(`QST_ADR_COUNT, 8'h04, "second boundary");
		rchk(`QST_ADR_STAT, 8'hC8, "second flag");
		wr(`QST_ADR_STAT, 8'hC0);
		repeat (600) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, "masked flag irq");
		rchk(`QST_ADR_STAT, 8'h80, "flag set while masked");
		wr(`QST_ADR_CTRL, 8'hB0);
		rchk(`QST_ADR_COUNT, 8'h00, "count clear");
		rchk(`QST_ADR_CTRL, 8'hA0, "clear bit reads zero");
		wr(`QST_ADR_CTRL, 8'h20);
		$display("Test flags and clear done");
		wr(`QST_ADR_MATCH, 8'h04);
		rchk(`QST_ADR_MATCH, 8'h04, "match readback");
		wr(`QST_ADR_STAT, 8'hE6);
		wr(`QST_ADR_CTRL, 8'hA0);
		wait_irq(2500);
		chk(8'(n >= 1950 && n <= 2100), 8'h01, "match after four ticks");
		rchk(`QST_ADR_COUNT, 8'h00, "upper bits zeroed");
		rchk(`QST_ADR_STAT, 8'hE6, "alarm flag");
		wr(`QST_ADR_STAT, 8'hE2);
		repeat (2100) @(posedge clk_i);
		chk({7'h00, irq_o}, 8'h00, "alarm irq disabled");
		rchk(`QST_ADR_STAT, 8'hE2, "alarm flag without irq");
		wr(`QST_ADR_MATCH, 8'h08);
		wb_xfer(1'b0, `QST_ADR_STAT, 8'h00);
		chk({7'h00, rd[0]}, 8'h01, "write pending");
		wr(`QST_ADR_MATCH, 8'h0C);
		repeat (600) @(posedge clk_i);
		rchk(`QST_ADR_MATCH, 8'h08, "pending write kept");
		wr(`QST_ADR_STAT, 8'hE0);
		// Long enough for the count to pass the new compare value
		repeat (4000) @(posedge clk_i);
		wb_xfer(1'b0, `QST_ADR_STAT, 8'h00);
		chk({7'h00, rd[5]}, 8'h00, "no match when off");
		wr(`QST_ADR_CTRL, 8'h20);
		$display("Test match done");
		wr(`QST_ADR_CTRL, 8'hA0);
		n = 0;
		repeat (300) @(posedge clk_i) n += int'(clk_out_o === 1'b1);
		chk(8'(n), 8'h00, "output idle when off");
		wr(`QST_ADR_CTRL, 8'h28);
		wr(`QST_ADR_CTRL, 8'hA8);
		n = 0;
		repeat (300) @(posedge clk_i) n += int'(clk_out_o === 1'b1);
		chk(8'(n > 50), 8'h01, "output runs when on");
		wr(`QST_ADR_CTRL, 8'h28);
		$display("Test clock output done");
		for (int i = 0; i < 2; i++) begin
			wr(`QST_ADR_CTRL, cb(1'b0, src_tab[i], div_tab[i]));
			wr(`QST_ADR_CTRL, cb(1'b1, src_tab[i], div_tab[i]));
			repeat (cyc_tab[i] - 400) @(posedge clk_i);
			rchk(`QST_ADR_COUNT, 8'h00, "before divided tick");
			repeat (800) @(posedge clk_i);
			rchk(`QST_ADR_COUNT, 8'h01, "divided tick");
			wr(`QST_ADR_CTRL, cb(1'b0, src_tab[i], div_tab[i]));
		end
		$display("Test dividers done");
		end_of_test();
	end
endmodule
